// File: rtca_defines.svh
// Register offsets, field positions, reset values and bus constants of the alarm interrupt unit.
`ifndef RTCA_DEFINES_SVH
`define RTCA_DEFINES_SVH

// Register offsets.
`define RTCA_OFF_ALARM_MINUTE     8'h08
`define RTCA_OFF_ALARM_HOUR       8'h09
`define RTCA_OFF_ALARM_DAY        8'h0A
`define RTCA_OFF_EXT_CONFIG       8'h0D
`define RTCA_OFF_EVENT_FLAGS      8'h0E
`define RTCA_OFF_IRQ_CONTROL      8'h0F

// Field positions.
`define RTCA_BIT_FIELD_MASK       7
`define RTCA_BIT_WEEK_OR_DAY      6
`define RTCA_BIT_UPDATE_FLAG      5
`define RTCA_BIT_TIMER_FLAG       4
`define RTCA_BIT_ALARM_FLAG       3
`define RTCA_BIT_LOW_VOLT_FLAG    1
`define RTCA_BIT_VOLT_DROP_FLAG   0
`define RTCA_BIT_ALARM_IRQ_EN     3
`define RTCA_BIT_CTRL_RESET       0
`define RTCA_POS_COMP_SEL_LO      6

// Writable masks; zero bits are fixed zero.
`define RTCA_MASK_EVENT_FLAGS     8'h3B
`define RTCA_MASK_IRQ_CONTROL     8'hF9

// Reset values.
`define RTCA_RST_ALARM            8'h00
`define RTCA_RST_EXT_CONFIG       8'h00
`define RTCA_RST_EVENT_FLAGS      8'h00
`define RTCA_RST_IRQ_CONTROL      8'h40

// Compensation periods in milliseconds, selected by the interval field.
`define RTCA_COMP_PERIOD0_MS      500
`define RTCA_COMP_PERIOD1_MS      2000
`define RTCA_COMP_PERIOD2_MS      10000
`define RTCA_COMP_PERIOD3_MS      30000

// Serial bus constants.
`define RTCA_SLAVE_ADDR           7'h32
`define RTCA_BITS_PER_BYTE        4'h8
`define RTCA_READ_EMPTY           8'h00

`endif

// File: rtca_pkg.sv
// Types shared by the alarm interrupt unit modules.
package rtca_pkg;

  // Serial slave states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    RTCA_IDLE     = 3'h0,
    RTCA_ADDR     = 3'h1,
    RTCA_ADDR_ACK = 3'h3,
    RTCA_RX_BYTE  = 3'h2,
    RTCA_RX_ACK   = 3'h6,
    RTCA_TX_BYTE  = 3'h7,
    RTCA_TX_ACK   = 3'h5
  } rtca_i2c_state_t;

  // Whole state of the top module.
  typedef struct packed {
    logic [2:0]      scl_sync;
    logic [2:0]      sda_sync;
    rtca_i2c_state_t st;
    logic [3:0]      cnt;
    logic [7:0]      shreg;
    logic [7:0]      txreg;
    logic [7:0]      ptr;
    logic            rw;
    logic            first;
    logic            nack;
    logic            sda_oe;
    logic [7:0]      alarm_minute;
    logic [7:0]      alarm_hour;
    logic [7:0]      alarm_day;
    logic [7:0]      ext_config;
    logic [7:0]      event_flags;
    logic [7:0]      irq_control;
    logic            irq_oe;
  } rtca_top_state_t;

  // Whole state of the matcher.
  typedef struct packed {
    logic event_pulse;
  } rtca_match_state_t;

endpackage

// File: rtca_alarm_match.sv
// Alarm comparator: checks masked alarm fields against the calendar at each minute rollover.
`include "rtca_defines.svh"

module rtca_alarm_match (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // Alarm settings.
  input  wire logic [7:0] alarm_minute_i,
  input  wire logic [7:0] alarm_hour_i,
  input  wire logic [7:0] alarm_day_i,
  input  wire logic       week_or_day_select_i,
  input  wire logic       hold_off_i,
  // Calendar.
  input  wire logic [6:0] cur_minute_i,
  input  wire logic [5:0] cur_hour_i,
  input  wire logic [6:0] cur_weekday_i,
  input  wire logic [5:0] cur_date_i,
  input  wire logic       minute_tick_i,
  // Result.
  output logic            event_o
);
  import rtca_pkg::*;

  rtca_match_state_t s;
  rtca_match_state_t next_s;
  logic              min_ok;
  logic              hour_ok;
  logic              day_ok;

  // A set mask bit removes its field from the match.
  always_comb begin
    min_ok  = alarm_minute_i[`RTCA_BIT_FIELD_MASK] || (alarm_minute_i[6:0] == cur_minute_i);
    hour_ok = alarm_hour_i[`RTCA_BIT_FIELD_MASK] || (alarm_hour_i[5:0] == cur_hour_i);
    if (alarm_day_i[`RTCA_BIT_FIELD_MASK]) begin
      day_ok = 1'b1;
    end else if (week_or_day_select_i) begin
      day_ok = (alarm_day_i[5:0] == cur_date_i);
    end else begin
      day_ok = |(alarm_day_i[6:0] & cur_weekday_i);
    end
  end

  // Only the rollover instant counts, so a setting equal to the present time waits for the next match.
  always_comb begin
    next_s             = s;
    next_s.event_pulse = minute_tick_i && !hold_off_i && min_ok && hour_ok && day_ok;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign event_o = s.event_pulse;
endmodule

// File: rtca_alarm_unit.sv
// Alarm interrupt unit top: serial register slave, alarm registers, flags and shared interrupt pin.
`include "rtca_defines.svh"

module rtca_alarm_unit (
  // Clock and reset.
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // Serial bus pins; data is open drain.
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Calendar from the time counters.
  input  wire logic [6:0] cur_minute_i,
  input  wire logic [5:0] cur_hour_i,
  input  wire logic [6:0] cur_weekday_i,
  input  wire logic [5:0] cur_date_i,
  input  wire logic       minute_tick_i,
  // Events of the neighbouring sources.
  input  wire logic       update_event_i,
  input  wire logic       timer_event_i,
  input  wire logic       low_voltage_event_i,
  input  wire logic       volt_drop_event_i,
  input  wire logic       other_irq_low_i,
  // Interrupt pin, open drain.
  output logic            irq_o,
  output logic            irq_oe_o,
  // Configuration seen by the rest of the clock.
  output logic [7:0]      ext_config_o,
  output logic [1:0]      comp_interval_sel_o
);
  import rtca_pkg::*;

  rtca_top_state_t s;
  rtca_top_state_t next_s;
  logic            alarm_event;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_cond;
  logic            stop_cond;
  logic            sda_now;
  logic            wr_en;
  logic [7:0]      wr_addr;
  logic [7:0]      wr_data;
  logic [7:0]      flag_set;
  logic [7:0]      flag_keep;

  // Register read decode; unmapped offsets read as zero.
  function automatic logic [7:0] rd_reg(input rtca_top_state_t st_in, input logic [7:0] addr);
    logic [7:0] v;
    v = `RTCA_READ_EMPTY;
    case (addr)
      `RTCA_OFF_ALARM_MINUTE: v = st_in.alarm_minute;
      `RTCA_OFF_ALARM_HOUR:   v = st_in.alarm_hour;
      `RTCA_OFF_ALARM_DAY:    v = st_in.alarm_day;
      `RTCA_OFF_EXT_CONFIG:   v = st_in.ext_config;
      `RTCA_OFF_EVENT_FLAGS:  v = st_in.event_flags & `RTCA_MASK_EVENT_FLAGS;
      `RTCA_OFF_IRQ_CONTROL:  v = st_in.irq_control & `RTCA_MASK_IRQ_CONTROL;
      default:                v = `RTCA_READ_EMPTY;
    endcase
    return v;
  endfunction

  rtca_alarm_match u_match (
    .core_clk_i           (core_clk_i),
    .rstn_i               (rstn_i),
    .alarm_minute_i       (s.alarm_minute),
    .alarm_hour_i         (s.alarm_hour),
    .alarm_day_i          (s.alarm_day),
    .week_or_day_select_i (s.ext_config[`RTCA_BIT_WEEK_OR_DAY]),
    .hold_off_i           (s.irq_control[`RTCA_BIT_CTRL_RESET]),
    .cur_minute_i         (cur_minute_i),
    .cur_hour_i           (cur_hour_i),
    .cur_weekday_i        (cur_weekday_i),
    .cur_date_i           (cur_date_i),
    .minute_tick_i        (minute_tick_i),
    .event_o              (alarm_event)
  );

  // Pin edges come from the second and third sync stages; the first stage feeds only the second.
  assign scl_rise   = s.scl_sync[1] && !s.scl_sync[2];
  assign scl_fall   = !s.scl_sync[1] && s.scl_sync[2];
  assign sda_now    = s.sda_sync[1];
  assign start_cond = s.scl_sync[1] && s.scl_sync[2] && !s.sda_sync[1] && s.sda_sync[2];
  assign stop_cond  = s.scl_sync[1] && s.scl_sync[2] && s.sda_sync[1] && !s.sda_sync[2];

  // Flag sources; the hardware set always wins over a clearing write in the same cycle.
  always_comb begin
    flag_set                            = 8'h00;
    flag_set[`RTCA_BIT_ALARM_FLAG]      = alarm_event;
    flag_set[`RTCA_BIT_UPDATE_FLAG]     = update_event_i;
    flag_set[`RTCA_BIT_TIMER_FLAG]      = timer_event_i;
    flag_set[`RTCA_BIT_LOW_VOLT_FLAG]   = low_voltage_event_i;
    flag_set[`RTCA_BIT_VOLT_DROP_FLAG]  = volt_drop_event_i;
  end

  // Serial slave: one bit per clock pulse, auto-incrementing register pointer.
  always_comb begin
    next_s          = s;
    wr_en           = 1'b0;
    wr_addr         = s.ptr;
    wr_data         = s.shreg;
    next_s.scl_sync = {s.scl_sync[1:0], scl_i};
    next_s.sda_sync = {s.sda_sync[1:0], sda_i};
    if (stop_cond) begin
      next_s.st     = RTCA_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (start_cond) begin
      next_s.st     = RTCA_ADDR;
      next_s.cnt    = 4'h0;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.st)
        RTCA_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        RTCA_ADDR: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda_now};
            next_s.cnt   = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == `RTCA_BITS_PER_BYTE) begin
            next_s.cnt = 4'h0;
            if (s.shreg[7:1] == `RTCA_SLAVE_ADDR) begin
              next_s.st     = RTCA_ADDR_ACK;
              next_s.rw     = s.shreg[0];
              next_s.sda_oe = 1'b1;
            end else begin
              next_s.st = RTCA_IDLE;
            end
          end
        end
        RTCA_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.cnt = 4'h0;
            if (s.rw) begin
              next_s.txreg  = rd_reg(s, s.ptr);
              next_s.sda_oe = !next_s.txreg[7];
              next_s.st     = RTCA_TX_BYTE;
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.first  = 1'b1;
              next_s.st     = RTCA_RX_BYTE;
            end
          end
        end
        RTCA_RX_BYTE: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda_now};
            next_s.cnt   = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == `RTCA_BITS_PER_BYTE) begin
            next_s.st     = RTCA_RX_ACK;
            next_s.sda_oe = 1'b1;
            next_s.first  = 1'b0;
            if (s.first) begin
              next_s.ptr = s.shreg;
            end else begin
              wr_en      = 1'b1;
              next_s.ptr = s.ptr + 8'h01;
            end
          end
        end
        RTCA_RX_ACK: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'b0;
            next_s.cnt    = 4'h0;
            next_s.st     = RTCA_RX_BYTE;
          end
        end
        RTCA_TX_BYTE: begin
          if (scl_fall) begin
            if (s.cnt == 4'h7) begin
              next_s.sda_oe = 1'b0;
              next_s.ptr    = s.ptr + 8'h01;
              next_s.st     = RTCA_TX_ACK;
            end else begin
              next_s.cnt    = s.cnt + 4'h1;
              next_s.txreg  = {s.txreg[6:0], 1'b0};
              next_s.sda_oe = !s.txreg[6];
            end
          end
        end
        RTCA_TX_ACK: begin
          if (scl_rise) begin
            next_s.nack = sda_now;
          end else if (scl_fall) begin
            next_s.cnt = 4'h0;
            if (s.nack) begin
              next_s.st = RTCA_IDLE;
            end else begin
              next_s.txreg  = rd_reg(s, s.ptr);
              next_s.sda_oe = !next_s.txreg[7];
              next_s.st     = RTCA_TX_BYTE;
            end
          end
        end
        default: begin
          next_s.st     = RTCA_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end

    // Register writes; fixed-zero bits are masked off.
    flag_keep = 8'hFF;
    if (wr_en) begin
      case (wr_addr)
        `RTCA_OFF_ALARM_MINUTE: next_s.alarm_minute = wr_data;
        `RTCA_OFF_ALARM_HOUR:   next_s.alarm_hour   = wr_data;
        `RTCA_OFF_ALARM_DAY:    next_s.alarm_day    = wr_data;
        `RTCA_OFF_EXT_CONFIG:   next_s.ext_config   = wr_data;
        `RTCA_OFF_EVENT_FLAGS:  flag_keep           = wr_data | ~`RTCA_MASK_EVENT_FLAGS;
        `RTCA_OFF_IRQ_CONTROL:  next_s.irq_control  = wr_data & `RTCA_MASK_IRQ_CONTROL;
        default:                flag_keep           = 8'hFF;
      endcase
    end
    // Writing 0 clears a flag, writing 1 leaves it; a new event in the same cycle still sets it.
    next_s.event_flags = ((s.event_flags & flag_keep) | flag_set) & `RTCA_MASK_EVENT_FLAGS;

    // The alarm pulls the pin only while flag and enable are both set, so clearing either releases it
    // on the next edge and nothing times out; other sources share the wired low.
    next_s.irq_oe = (next_s.event_flags[`RTCA_BIT_ALARM_FLAG]
                     && next_s.irq_control[`RTCA_BIT_ALARM_IRQ_EN])
                    || other_irq_low_i;
  end

  // Single state register; the control reset value loads the two-second compensation period.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s              <= '0;
      s.scl_sync     <= 3'h7;
      s.sda_sync     <= 3'h7;
      s.st           <= RTCA_IDLE;
      s.alarm_minute <= `RTCA_RST_ALARM;
      s.alarm_hour   <= `RTCA_RST_ALARM;
      s.alarm_day    <= `RTCA_RST_ALARM;
      s.ext_config   <= `RTCA_RST_EXT_CONFIG;
      s.event_flags  <= `RTCA_RST_EVENT_FLAGS;
      s.irq_control  <= `RTCA_RST_IRQ_CONTROL;
    end else begin
      s <= next_s;
    end
  end

  // Open-drain pins only ever drive low.
  assign sda_o               = 1'b0;
  assign sda_oe_o            = s.sda_oe;
  assign irq_o               = 1'b0;
  assign irq_oe_o            = s.irq_oe;
  assign ext_config_o        = s.ext_config;
  assign comp_interval_sel_o = s.irq_control[7:`RTCA_POS_COMP_SEL_LO];
endmodule

// File: rtca_i2c_host.sv
// Behavioural serial bus master standing in for the host processor.
module rtca_i2c_host (
  // Device side of the open-drain data line.
  input  wire logic dev_low_i,
  // Resolved bus lines.
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_low = 1'b0;
  initial scl_o = 1'b1;
  // The data line has a pull-up, so a released data line reads high, never a stale value.
  assign sda_o = !(m_low || dev_low_i);

  // Data moves in the low phase and is sampled mid high phase, one bit per pulse.
  task automatic bit_x(input logic b, output logic q);
    m_low = !b;
    #40 scl_o = 1'b1;
    #40 q = sda_o;
    #40 scl_o = 1'b0;
    #40;
  endtask

  // Byte out, most significant bit first, then the ninth clock for the answer.
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q);
    bit_x(1'b1, q);
    ack = !q;
  endtask

  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, q);
  endtask

  // Start or repeated start; the clock only runs inside frames.
  task automatic start();
    m_low = 1'b0;
    #40 scl_o = 1'b1;
    #80 m_low = 1'b1;
    #80 scl_o = 1'b0;
    #40;
  endtask

  task automatic stop();
    m_low = 1'b1;
    #40 scl_o = 1'b1;
    #80 m_low = 1'b0;
    #80;
  endtask

  // One register access: pointer write, then data out or a repeated start and one read byte.
  task automatic acc(input logic rd, input logic [7:0] a, inout logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    byte_tx(8'h64, k1);
    byte_tx(a, k2);
    if (rd) begin
      start();
      byte_tx(8'h65, k3);
      byte_rx(1'b1, d);
    end else byte_tx(d, k3);
    stop();
    ok = k1 && k2 && k3;
  endtask
endmodule

// File: rtca_alarm_unit_sva.sv
// Port-level assertions of the alarm interrupt unit.
module rtca_alarm_unit_sva (
  // Clock and reset.
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  // Watched pins.
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       minute_tick_i,
  input wire logic       other_irq_low_i,
  input wire logic       irq_o,
  input wire logic       irq_oe_o,
  input wire logic [7:0] ext_config_o,
  input wire logic [1:0] comp_interval_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_irq_wired: assert property (other_irq_low_i |=> irq_oe_o)
    else $error("irq pin not pulled for other source");
  // An alarm can only pull the pin two edges after a minute tick: match pulse, then flag and pin together.
  chk_irq_from_tick: assert property ($rose(irq_oe_o) && !$past(other_irq_low_i) |-> $past(minute_tick_i, 2))
    else $error("irq pin rose without a minute tick");
  chk_irq_holds: assert property ($rose(irq_oe_o) && !$past(other_irq_low_i) |=> irq_oe_o[*4])
    else $error("alarm irq dropped on its own");
  // A release needs a register write, which the device acknowledges, or the other source letting go of the pin.
  chk_irq_release: assert property ($fell(irq_oe_o) |-> !$past(other_irq_low_i)
    && ($past(other_irq_low_i, 2) || sda_oe_o || $past(sda_oe_o) || $past(sda_oe_o, 2)))
    else $error("irq pin released without a write");
  chk_ack_stands: assert property ($rose(sda_oe_o) |=> sda_oe_o[*8])
    else $error("data line pull too short");
  chk_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
  chk_cfg_on_ack: assert property ($changed(ext_config_o) || $changed(comp_interval_sel_o) |-> ##[0:2] sda_oe_o)
    else $error("config changed outside a write");
  chk_open_drain: assert property (!sda_o && !irq_o)
    else $error("open drain value not low");

  cover property ($rose(irq_oe_o) && !$past(other_irq_low_i));
  cover property ($rose(sda_oe_o));
  cover property ($changed(comp_interval_sel_o));
endmodule

// File: tb.sv
// Top bench: host model, reference model and the alarm unit.
bind rtca_alarm_unit rtca_alarm_unit_sva u_chk (.core_clk_i, .rstn_i, .scl_i, .sda_o, .sda_oe_o,
  .minute_tick_i, .other_irq_low_i, .irq_o, .irq_oe_o, .ext_config_o, .comp_interval_sel_o);

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        minute_tick_i = 1'b0;
  logic        other_irq_low_i = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic [6:0]  cur_minute_i = 7'h00;
  logic [5:0]  cur_hour_i = 6'h00;
  logic [6:0]  cur_weekday_i = 7'h01;
  logic [5:0]  cur_date_i = 6'h01;
  logic        scl, sda, sda_oe_o, irq_oe_o, ack;
  logic [7:0]  ext_config_o, d;
  logic [1:0]  comp_interval_sel_o;
  logic [31:0] seed = 32'h7AE4;
  logic [31:0] r;
  int          errors = 0;
  int          cmp_count = 0;
  int          m [256];
  logic [7:0]  regs [7] = '{8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h20};
  logic [6:0]  mins [4] = '{7'h00, 7'h15, 7'h30, 7'h59};
  logic [5:0]  hrs [4] = '{6'h00, 6'h07, 6'h12, 6'h23};
  logic [5:0]  dts [4] = '{6'h01, 6'h09, 6'h15, 6'h31};

  rtca_i2c_host host (.dev_low_i(sda_oe_o), .scl_o(scl), .sda_o(sda));
  rtca_alarm_unit DUT (.core_clk_i, .rstn_i, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o,
    .cur_minute_i, .cur_hour_i, .cur_weekday_i, .cur_date_i, .minute_tick_i,
    .update_event_i(ev[3]), .timer_event_i(ev[2]), .low_voltage_event_i(ev[1]), .volt_drop_event_i(ev[0]),
    .other_irq_low_i, .irq_o(), .irq_oe_o, .ext_config_o, .comp_interval_sel_o);

  // Free-running core clock.
  initial forever #5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Register write through the host, mirrored into the model.
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    logic ok;
    host.acc(1'b0, a, v, ok);
    check("write ack", {7'h00, ok}, 8'h01);
    case (a)
      8'h0E: m[a] &= v;
      8'h0F: m[a] = v & 8'hF9;
      8'h08, 8'h09, 8'h0A, 8'h0D: m[a] = v;
      default: ;
    endcase
  endtask

  task automatic rchk(input logic [7:0] a);
    logic ok;
    host.acc(1'b1, a, d, ok);
    check("read ack", {7'h00, ok}, 8'h01);
    check($sformatf("reg %h", a), d, 8'(m[a]));
  endtask

  task automatic irq_chk();
    check("irq pin", {7'h00, irq_oe_o}, {7'h00, m[14][3] && m[15][3] || other_irq_low_i});
  endtask

  // One minute rollover with random calendar values, often equal to the alarm.
  task automatic tick();
    logic [6:0] mi, wd;
    logic [5:0] hr, dt;
    logic       hit;
    // Line up with a falling edge first, so the tick pulse spans one whole clock cycle.
    @(negedge core_clk_i);
    r = rnd();
    mi = r[0] ? m[8][6:0] : mins[r[2:1]];
    hr = r[3] ? m[9][5:0] : hrs[r[5:4]];
    dt = r[6] ? m[10][5:0] : dts[r[8:7]];
    wd = 7'h01 << (r[11:9] % 3'h7);
    hit = (m[8][7] || m[8][6:0] == mi) && (m[9][7] || m[9][5:0] == hr)
      && (m[10][7] || (m[13][6] ? m[10][5:0] == dt : |(m[10][6:0] & wd)));
    {cur_minute_i, cur_hour_i, cur_weekday_i, cur_date_i} = {mi, hr, wd, dt};
    minute_tick_i = 1'b1;
    ev = r[15:12];
    other_irq_low_i = r[16] && r[17];
    @(negedge core_clk_i);
    minute_tick_i = 1'b0;
    ev = 4'h0;
    repeat (4) @(negedge core_clk_i);
    m[14] |= {2'b00, r[15:14], hit && !m[15][0], 1'b0, r[13:12]};
    irq_chk();
  endtask

  // Main sequence: reset values, refusals, then alarm configurations.
  initial begin
    m = '{default: 0};
    m[15] = 32'h40;
    repeat (8) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check("comp select", {6'h00, comp_interval_sel_o}, 8'h01);
    host.start();
    host.byte_tx(8'h66, ack);
    host.stop();
    check("foreign ack", {7'h00, ack}, 8'h00);
    wreg(8'h20, 8'h5A);
    foreach (regs[k]) rchk(regs[k]);
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      wreg(8'h0F, 8'h40);
      wreg(8'h08, {i == 0 || r[0] && r[1], mins[r[3:2]]});
      wreg(8'h09, {i == 0 || r[4] && r[5], r[6], hrs[r[8:7]]});
      wreg(8'h0D, r[31:24]);
      wreg(8'h0A, i < 2 ? 8'h80 : {r[9] && r[10], r[30] ? {r[20], dts[r[15:14]]} : r[20:14]});
      wreg(8'h0F, {i[1:0], r[23:22], i != 3, 2'b11, i == 4});
      check("comp select", {6'h00, comp_interval_sel_o}, {6'h00, i[1:0]});
      check("ext copy", ext_config_o, 8'(m[13]));
      irq_chk();
      if (i < 2) foreach (regs[k]) rchk(regs[k]);
      for (int t = 0; t < 3; t++) begin
        tick();
        if (t == 0) wreg(8'h0E, 8'hFF);
        rchk(8'h0E);
        irq_chk();
        if (t == 1) begin
          wreg(8'h0F, 8'(m[15]) & 8'hF7);
          irq_chk();
        end
        wreg(8'h0E, 8'h00);
        irq_chk();
      end
    end
    tally_and_finish();
  end

  // Watchdog sized above the expected run of about 86,000 cycles, yet inside the cycle budget.
  initial begin
    #980000;
    errors++;
    tally_and_finish();
  end
endmodule
